// ### hdl/ctrl_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the global
  command and miscellaneous control block.
  Assumes it is included by bare name from every file that needs a number.
*/
`ifndef CTRL_CONSTS_SVH
`define CTRL_CONSTS_SVH

`define MISC_CTRL_LO_ADDR    7'h34
`define MISC_CTRL_HI_ADDR    7'h35
`define CMD_TRIG_LO_ADDR     7'h3E
`define CMD_TRIG_HI_ADDR     7'h3F
`define MISC_CTRL_RESET      16'h0000
`define READ_WORD_RESET      16'h0000

`define CMD_SOFT_RESET_BIT   7
`define CMD_FLASH_SAVE_BIT   3
`define CMD_DAC_LATCH_BIT    2
`define CMD_FACTORY_BIT      1
`define CMD_NULL_BIT         0

`define MISC_SELF_TEST_BIT   8
`define MISC_DR_ENABLE_BIT   2
`define MISC_DR_POLARITY_BIT 1
`define MISC_DR_SELECT_BIT   0

`define FRAME_BITS           16
`define FRAME_WRITE_BIT      15
`define FRAME_ADDR_MSB       14
`define FRAME_ADDR_LSB       8

`define OFFSET_NOMINAL       12'h000
`define SCALE_NOMINAL        12'h800

`define FLASH_SAVE_MS        50
`define CLK_FREQ_KHZ         200000

`endif

// ### hdl/ctrl_pkg.sv
/*
  Types shared by the command and miscellaneous control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctrl_pkg;

  // gray order along idle -> run -> done
  typedef enum logic [1:0]
  {
    SAVE_IDLE = 2'h0,
    SAVE_RUN  = 2'h1,
    SAVE_DONE = 2'h3
  } flash_state_e;

endpackage

// ### hdl/global_command_and_misc_control.sv
/*
  Global command register and miscellaneous control register with the
  data-ready pin logic, flash save timer and converter latch.
  Assumes the sampling engine gives one-cycle pulses on clk, the alarm and
  general pin logic give their wishes for each line on clk, and the host
  keeps cs_b high for at least 100 ns between frames.
*/
`include "ctrl_consts.svh"

module global_command_and_misc_control
#(
  parameter int unsigned FLASH_SAVE_CYCLES = `FLASH_SAVE_MS * `CLK_FREQ_KHZ,
  parameter int          DAC_BITS          = 12
)
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                sclk,
  input  wire logic                cs_b,
  input  wire logic                din,
  output logic                     dout,
  input  wire logic                sample_done,
  input  wire logic                sample_midway,
  input  wire logic [1:0]          alarm_pin_enable,
  input  wire logic [1:0]          alarm_pin_level,
  input  wire logic [1:0]          gpio_pin_output,
  input  wire logic [1:0]          gpio_pin_level,
  input  wire logic [DAC_BITS-1:0] aux_dac_word,
  output logic [1:0]               pin_out,
  output logic [1:0]               pin_oe_b,
  output logic [DAC_BITS-1:0]      dac_code,
  output logic                     software_reset,
  output logic                     flash_save_start,
  output logic                     flash_busy,
  output logic                     calib_restore,
  output logic                     filter_clear,
  output logic                     offset_null,
  output logic [11:0]              offset_load_value,
  output logic [11:0]              scale_load_value,
  output logic                     sensor_diagnostic_mode
);

  localparam int CW = $clog2(FLASH_SAVE_CYCLES + 1);

  if (FLASH_SAVE_CYCLES < 2 || DAC_BITS < 1 || DAC_BITS > 16)
  begin : param_check
    $error("flash save needs two cycles and DAC_BITS must be 1 to 16");
  end

  logic [15:0]            frame_word;
  logic                   frame_toggle;
  logic                   toggle_sync;
  logic                   toggle_seen;
  logic                   frame_valid;
  logic                   frame_write;
  logic [6:0]             frame_addr;
  logic [7:0]             frame_data;
  logic                   cmd_write;
  logic                   misc_lo_write;
  logic                   misc_hi_write;
  logic                   save_req;
  logic                   dac_latch;
  logic [15:0]            read_word;
  logic [2:0]             dr_config;
  logic                   dr_enable;
  logic                   dr_polarity;
  logic                   dr_select;
  logic                   dr_active;
  logic [CW-1:0]          flash_count;
  ctrl_pkg::flash_state_e flash_state;

  ////////////////////////////////////////////////////////////////////////////
  // link side and crossing
  serial_frame_port link_port
  (
    .sclk         (sclk),
    .rst_b        (rst_b),
    .cs_b         (cs_b),
    .din          (din),
    .read_word    (read_word),
    .frame_word   (frame_word),
    .frame_toggle (frame_toggle),
    .dout         (dout)
  );

  level_sync #(.WIDTH(1)) frame_sync
  (
    .clk         (clk),
    .rst_b       (rst_b),
    .async_level (frame_toggle),
    .sync_level  (toggle_sync)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      toggle_seen <= 1'b0;
    end
    else
    begin
      toggle_seen <= toggle_sync;
    end
  end

  // frame_word is quiet for a whole frame once the toggle has crossed
  assign frame_valid   = toggle_sync ^ toggle_seen;
  assign frame_write   = frame_word[`FRAME_WRITE_BIT];
  assign frame_addr    = frame_word[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
  assign frame_data    = frame_word[7:0];
  assign cmd_write     = frame_valid && frame_write && frame_addr == `CMD_TRIG_LO_ADDR;
  assign misc_lo_write = frame_valid && frame_write && frame_addr == `MISC_CTRL_LO_ADDR;
  assign misc_hi_write = frame_valid && frame_write && frame_addr == `MISC_CTRL_HI_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // command pulses, nothing retained
  assign save_req = cmd_write && (frame_data[`CMD_FLASH_SAVE_BIT] ||
                                  frame_data[`CMD_FACTORY_BIT] ||
                                  frame_data[`CMD_NULL_BIT]);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      software_reset <= 1'b0;
      dac_latch      <= 1'b0;
      calib_restore  <= 1'b0;
      filter_clear   <= 1'b0;
      offset_null    <= 1'b0;
    end
    else
    begin
      software_reset <= cmd_write && frame_data[`CMD_SOFT_RESET_BIT];
      dac_latch      <= cmd_write && frame_data[`CMD_DAC_LATCH_BIT];
      calib_restore  <= cmd_write && frame_data[`CMD_FACTORY_BIT];
      filter_clear   <= cmd_write && frame_data[`CMD_FACTORY_BIT];
      offset_null    <= cmd_write && frame_data[`CMD_NULL_BIT];
    end
  end

  // nominal values ride with the restore pulse
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      offset_load_value <= `OFFSET_NOMINAL;
      scale_load_value  <= `SCALE_NOMINAL;
    end
    else if (cmd_write && frame_data[`CMD_FACTORY_BIT])
    begin
      offset_load_value <= `OFFSET_NOMINAL;
      scale_load_value  <= `SCALE_NOMINAL;
    end
  end

  // converter holds its code until the latch or a software reset, whatever the data bytes do
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_code <= '0;
    end
    else if (software_reset || dac_latch)
    begin
      dac_code <= software_reset ? '0 : aux_dac_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash save timer; a request while busy is dropped
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flash_state      <= ctrl_pkg::SAVE_IDLE;
      flash_count      <= '0;
      flash_busy       <= 1'b0;
      flash_save_start <= 1'b0;
    end
    else
    begin
      flash_save_start <= 1'b0;
      case (flash_state)
        ctrl_pkg::SAVE_IDLE:
        begin
          if (save_req)
          begin
            flash_state      <= ctrl_pkg::SAVE_RUN;
            flash_count      <= CW'(FLASH_SAVE_CYCLES - 1);
            flash_busy       <= 1'b1;
            flash_save_start <= 1'b1;
          end
        end
        ctrl_pkg::SAVE_RUN:
        begin
          if (flash_count == '0)
          begin
            flash_state <= ctrl_pkg::SAVE_DONE;
          end
          else
          begin
            flash_count <= flash_count - CW'(1);
          end
        end
        ctrl_pkg::SAVE_DONE:
        begin
          flash_state <= ctrl_pkg::SAVE_IDLE;
          flash_busy  <= 1'b0;
        end
        default:
        begin
          flash_state <= ctrl_pkg::SAVE_IDLE;
          flash_busy  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // miscellaneous register
  // data-ready settings clear only at power-on, never on the software reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dr_config <= 3'(`MISC_CTRL_RESET);
    end
    else if (misc_lo_write)
    begin
      dr_config <= frame_data[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sensor_diagnostic_mode <= 1'b0;
    end
    else if (software_reset)
    begin
      sensor_diagnostic_mode <= 1'b0;
    end
    else if (misc_hi_write)
    begin
      sensor_diagnostic_mode <= frame_data[`MISC_SELF_TEST_BIT - 8];
    end
  end

  assign dr_enable   = dr_config[`MISC_DR_ENABLE_BIT];
  assign dr_polarity = dr_config[`MISC_DR_POLARITY_BIT];
  assign dr_select   = dr_config[`MISC_DR_SELECT_BIT];

  // read answer for the next frame; the command register reads as zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_word <= `READ_WORD_RESET;
    end
    else if (frame_valid && !frame_write)
    begin
      if (frame_addr == `MISC_CTRL_LO_ADDR || frame_addr == `MISC_CTRL_HI_ADDR)
      begin
        read_word <= {7'h00, sensor_diagnostic_mode, 5'h00, dr_config};
      end
      else
      begin
        read_word <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data-ready pulse train
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dr_active <= 1'b0;
    end
    else if (!dr_enable || software_reset)
    begin
      dr_active <= 1'b0;
    end
    else if (sample_done)
    begin
      dr_active <= 1'b1;
    end
    else if (sample_midway)
    begin
      dr_active <= 1'b0;
    end
  end

  // pin ownership: data-ready, then alarm, then general control
  for (genvar i = 0; i < 2; i++)
  begin : pin_mux
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        pin_out[i]  <= 1'b0;
        pin_oe_b[i] <= 1'b1;
      end
      else if (dr_enable && dr_select == 1'(i))
      begin
        pin_out[i]  <= dr_polarity ? dr_active : ~dr_active;
        pin_oe_b[i] <= 1'b0;
      end
      else if (alarm_pin_enable[i] || gpio_pin_output[i])
      begin
        pin_out[i]  <= alarm_pin_enable[i] ? alarm_pin_level[i] : gpio_pin_level[i];
        pin_oe_b[i] <= 1'b0;
      end
      else
      begin
        pin_out[i]  <= 1'b0;
        pin_oe_b[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence reset_cmd_s;
    cmd_write && frame_data[`CMD_SOFT_RESET_BIT];
  endsequence

  sequence factory_cmd_s;
    cmd_write && frame_data[`CMD_FACTORY_BIT] && !flash_busy;
  endsequence

  soft_reset_pulse_a: assert property (reset_cmd_s |=> software_reset ##1 !software_reset)
    else $error("software reset pulse missing or held");
  reset_keeps_dr_a: assert property (
    software_reset |=> !sensor_diagnostic_mode && $stable(dr_config))
    else $error("reset lost data-ready setup or kept self-test");
  dac_hold_a: assert property (!dac_latch && !software_reset |=> $stable(dac_code))
    else $error("converter code moved without latch");
  restore_saves_a: assert property (
    factory_cmd_s |=> calib_restore && flash_save_start ##1 flash_busy)
    else $error("factory restore did not start a flash save");
  flash_hold_a: assert property (flash_state == ctrl_pkg::SAVE_RUN && flash_count != '0
    |=> flash_busy && flash_state == ctrl_pkg::SAVE_RUN)
    else $error("flash save ended early");
  dr_assert_a: assert property (
    dr_enable && sample_done && !software_reset ##1 dr_enable && dr_select == $past(dr_select)
    |=> pin_out[$past(dr_select)] == $past(dr_polarity) && !pin_oe_b[$past(dr_select)])
    else $error("data-ready pin not asserted after sample");
  dr_release_a: assert property (dr_active && sample_midway && !sample_done |=> !dr_active)
    else $error("data-ready did not release midway");
  misc_priority_a: assert property (
    dr_enable && !dr_select ##1 dr_enable && !dr_select
    |-> !pin_oe_b[0] && pin_out[0] == ($past(dr_polarity) ? $past(dr_active) : !$past(dr_active)))
    else $error("data-ready lost pin zero to a lower owner");
  selftest_write_a: assert property (
    misc_hi_write && !software_reset |=> sensor_diagnostic_mode == $past(frame_data[0]))
    else $error("self-test bit not taken from write");
  cmd_no_retain_a: assert property (calib_restore |=> !calib_restore)
    else $error("command bit retained");

endmodule

// ### hdl/level_sync.sv
/*
  Two flip-flop synchroniser for a level from a foreign clock domain.
  Assumes the level is stable for at least two destination clock periods.
*/
module level_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_level,
  output logic      [WIDTH-1:0] sync_level
);

  logic [WIDTH-1:0] stage_one;

  if (WIDTH < 1)
  begin : width_check
    $error("level_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one  <= '0;
      sync_level <= '0;
    end
    else
    begin
      stage_one  <= async_level;
      sync_level <= stage_one;
    end
  end

endmodule

// ### hdl/serial_frame_port.sv
/*
  Serial slave port on the link clock: gathers 16-bit frames and shifts a
  read answer out.
  Assumes sclk idles high, data is sampled on rising edges, cs_b is held
  high between frames, and read_word is stable while a frame runs.
*/
`include "ctrl_consts.svh"

module serial_frame_port
(
  input  wire logic        sclk,
  input  wire logic        rst_b,
  input  wire logic        cs_b,
  input  wire logic        din,
  input  wire logic [15:0] read_word,
  output logic      [15:0] frame_word,
  output logic             frame_toggle,
  output logic             dout
);

  logic [3:0]  bit_count;
  logic [14:0] shift_in;

  ////////////////////////////////////////////////////////////////////////////
  // frame assembly, cleared by the frame's own select
  always_ff @(posedge sclk or posedge cs_b)
  begin
    if (cs_b)
    begin
      bit_count <= 4'h0;
      shift_in  <= 15'h0000;
    end
    else
    begin
      bit_count <= bit_count + 4'h1;
      shift_in  <= {shift_in[13:0], din};
    end
  end

  // completed word and event toggle, held across the gap between frames
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_word   <= 16'h0000;
      frame_toggle <= 1'b0;
    end
    else if (!cs_b && bit_count == 4'hF)
    begin
      frame_word   <= {shift_in, din};
      frame_toggle <= ~frame_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer msb first; bit 15 of every readable word is zero
  always_ff @(negedge sclk or posedge cs_b)
  begin
    if (cs_b)
    begin
      dout <= 1'b0;
    end
    else
    begin
      dout <= read_word[4'hF - bit_count];
    end
  end

endmodule

// ### verification/serial_host_model.sv
/*
  Behavioural serial host that frames 16-bit words on the link port.
  Assumes the device samples din on rising sclk and shifts dout on falling sclk.
*/
module serial_host_model
(
  output logic      sclk,
  output logic      cs_b,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 15;

  initial
  begin
    sclk = 1'b1;
    cs_b = 1'b0;
    din  = 1'b0;
    // a rising select at start clears the device's bit counter and answer bit
    #2;
    cs_b = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame: flag and address byte, then data byte, msb first
  task automatic xfer(input logic [15:0] word, output logic [15:0] answer);
    answer = 16'h0000;
    cs_b = 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = word[i];
      #HALF;
      sclk = 1'b1;
      answer[i] = dout;
      #HALF;
    end
    cs_b = 1'b1;
    // released line shows the inverse of the last bit
    din = ~word[0];
    #150;
  endtask
endmodule

// ### verification/test_global_command_and_misc_control.sv
/*
  Self-checking bench for the command and miscellaneous control block.
  Assumes serial_host_model drives the link port; the save time is shortened.
*/
module test_global_command_and_misc_control;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SAVE_CYC = 20;

  logic        clk, rst_b, sclk, cs_b, din, dout;
  logic        sample_done, sample_midway;
  logic [1:0]  alarm_pin_enable, alarm_pin_level, gpio_pin_output, gpio_pin_level;
  logic [11:0] aux_dac_word, dac_code, offset_load_value, scale_load_value;
  logic [1:0]  pin_out, pin_oe_b;
  logic        software_reset, flash_save_start, flash_busy, calib_restore;
  logic        filter_clear, offset_null, sensor_diagnostic_mode;
  logic [6:0]  pv;
  logic [15:0] rd;
  int          err_count = 0;
  int          checks = 0;
  int          cnt [7] = '{default: 0};

  global_command_and_misc_control #(.FLASH_SAVE_CYCLES(SAVE_CYC)) u_global_command_and_misc_control
  (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout),
    .sample_done(sample_done), .sample_midway(sample_midway),
    .alarm_pin_enable(alarm_pin_enable), .alarm_pin_level(alarm_pin_level),
    .gpio_pin_output(gpio_pin_output), .gpio_pin_level(gpio_pin_level),
    .aux_dac_word(aux_dac_word), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .dac_code(dac_code), .software_reset(software_reset),
    .flash_save_start(flash_save_start), .flash_busy(flash_busy),
    .calib_restore(calib_restore), .filter_clear(filter_clear),
    .offset_null(offset_null), .offset_load_value(offset_load_value),
    .scale_load_value(scale_load_value), .sensor_diagnostic_mode(sensor_diagnostic_mode)
  );

  serial_host_model u_serial_host_model
  (
    .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts of each pulse output
  assign pv = {flash_busy, calib_restore & filter_clear, offset_null, filter_clear,
               calib_restore, flash_save_start, software_reset};

  always @(posedge clk)
    foreach (cnt[i]) cnt[i] <= cnt[i] + int'(pv[i] === 1'b1);

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] pins();
    return {12'h000, pin_oe_b, pin_out};
  endfunction

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] ans;
    u_serial_host_model.xfer({1'b1, addr, data}, ans);
  endtask

  // the answer to a read arrives in the following frame
  task automatic rd_reg(input logic [6:0] addr, output logic [15:0] word);
    logic [15:0] ans;
    u_serial_host_model.xfer({1'b0, addr, 8'h00}, ans);
    u_serial_host_model.xfer(16'h0000, word);
  endtask

  task automatic cmd_check(input logic [6:0] addr, input logic [7:0] bits,
                           input logic [5:0] exp, input int busy);
    int base [7];
    base = cnt;
    wr(addr, bits);
    repeat (40) @(negedge clk);
    for (int i = 0; i < 6; i++)
      check("command pulse cycles", 16'(exp[i]), 16'(cnt[i] - base[i]));
    check("save busy cycles", 16'(busy), 16'(cnt[6] - base[6]));
  endtask

  task automatic samp(input logic d, input logic m);
    @(negedge clk);
    sample_done = d;
    sample_midway = m;
    @(negedge clk);
    sample_done = 1'b0;
    sample_midway = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic set_lines(input logic [7:0] v);
    @(negedge clk);
    {alarm_pin_enable, alarm_pin_level, gpio_pin_output, gpio_pin_level} = v;
    repeat (2) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    check("output enables", 16'h0003, 16'(pin_oe_b));
    check("converter code", 16'h0000, 16'(dac_code));
    check("offset nominal", 16'h0000, 16'(offset_load_value));
    check("scale nominal", 16'h0800, 16'(scale_load_value));
    check("self-test", 16'h0000, 16'(sensor_diagnostic_mode));
    rd_reg(7'h34, rd);
    check("misc register", 16'h0000, rd);
  endtask

  task automatic t_dac_latch();
    @(negedge clk);
    aux_dac_word = 12'hABC;
    wr(7'h31, 8'h0A);
    wr(7'h30, 8'hBC);
    check("code before latch", 16'h0000, 16'(dac_code));
    cmd_check(7'h3E, 8'h04, 6'h00, 0);
    check("code after latch", 16'h0ABC, 16'(dac_code));
    @(negedge clk);
    aux_dac_word = 12'h123;
    repeat (10) @(negedge clk);
    check("code held", 16'h0ABC, 16'(dac_code));
  endtask

  task automatic t_commands();
    cmd_check(7'h3E, 8'h02, 6'b101110, SAVE_CYC + 1);
    cmd_check(7'h3E, 8'h01, 6'b010010, SAVE_CYC + 1);
    cmd_check(7'h3E, 8'h08, 6'b000010, SAVE_CYC + 1);
    cmd_check(7'h3E, 8'h0B, 6'b111110, SAVE_CYC + 1);
    cmd_check(7'h3E, 8'h00, 6'h00, 0);
    cmd_check(7'h3F, 8'hFF, 6'h00, 0);
    rd_reg(7'h3E, rd);
    check("command readback", 16'h0000, rd);
  endtask

  task automatic t_data_ready();
    set_lines(8'b11_10_11_01);
    check("alarm over general", 16'h0002, pins());
    wr(7'h34, 8'h06);
    samp(1'b1, 1'b0);
    check("ready high line 0", 16'h0003, pins());
    samp(1'b0, 1'b1);
    check("ready inactive", 16'h0002, pins());
    samp(1'b1, 1'b1);
    check("ready again", 16'h0003, pins());
    set_lines(8'b00_10_11_01);
    check("general drives line 1", 16'h0001, pins());
    set_lines(8'b00_10_00_01);
    check("line 1 released", 16'h0009, pins());
    wr(7'h34, 8'h05);
    samp(1'b0, 1'b1);
    check("active low idle line 1", 16'h0006, pins());
    samp(1'b1, 1'b0);
    check("active low asserted", 16'h0004, pins());
    wr(7'h34, 8'h01);
    repeat (4) @(negedge clk);
    check("ready disabled", 16'h000C, pins());
  endtask

  task automatic t_self_test();
    wr(7'h34, 8'h06);
    wr(7'h35, 8'h01);
    check("self-test on", 16'h0001, 16'(sensor_diagnostic_mode));
    rd_reg(7'h34, rd);
    check("misc readback", 16'h0106, rd);
    cmd_check(7'h3E, 8'h80, 6'b000001, 0);
    check("self-test after reset", 16'h0000, 16'(sensor_diagnostic_mode));
    check("code after reset", 16'h0000, 16'(dac_code));
    rd_reg(7'h35, rd);
    check("kept ready setup", 16'h0006, rd);
    wr(7'h35, 8'h01);
    wr(7'h35, 8'h00);
    check("self-test off", 16'h0000, 16'(sensor_diagnostic_mode));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    test_done();
  end

  initial
  begin
    rst_b = 1'b1;
    sample_done = 1'b0;
    sample_midway = 1'b0;
    {alarm_pin_enable, alarm_pin_level, gpio_pin_output, gpio_pin_level} = 8'h00;
    aux_dac_word = 12'h000;
    // a clean falling reset reaches the link side, which sees no clk edges
    @(negedge clk);
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_values();
    t_dac_latch();
    t_commands();
    t_data_ready();
    t_self_test();
    test_done();
  end
endmodule
